/* File: icfe_top.sv */
// Command front end: decode, page write, response bytes
`timescale 1ns/1ps
module icfe_top
    import icfe_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int DEPTH  = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Received byte stream from the serial slave
    input  wire logic [7:0]  rx_byte_in,
    input  wire logic        rx_valid_in,
    output logic             rx_ready_out,
    input  wire logic        rx_addr_in,
    input  wire logic        rx_stop_in,
    // Response byte stream to the serial slave
    output logic [7:0]       tx_byte_out,
    output logic             tx_valid_out,
    input  wire logic        tx_ready_in,
    // Memory programming port
    output logic [2:0]       mem_page_out,
    output logic [4:0]       mem_addr_out,
    output logic [7:0]       mem_data_out,
    output logic             mem_we_out,
    // Command strobes to the rest of the device
    output logic [3:0]       cmd_class_out,
    output logic             cmd_start_out,
    output logic             master_reset_out,
    output logic             busy_out
);
    // Input buffer between the serial slave and the decoder
    logic [DATA_W-1:0] fb_data;
    logic              fb_valid;
    logic              fb_ready;
    logic              fb_addr;
    logic              fb_stop;
    logic [9:0]        fb_in;
    logic [9:0]        fb_out;
    assign fb_in = {rx_stop_in, rx_addr_in, rx_byte_in};

    icfe_fifo #(
        .WIDTH (10),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .wr_data_in   (fb_in),
        .wr_valid_in  (rx_valid_in),
        .wr_ready_out (rx_ready_out),
        .rd_data_out  (fb_out),
        .rd_valid_out (fb_valid),
        .rd_ready_in  (fb_ready)
    );
    assign fb_data = fb_out[7:0];
    assign fb_addr = fb_out[8];
    assign fb_stop = fb_out[9];

    // Command code to class
    function automatic icfe_cmd_t decode_cmd(input logic [7:0] c);
        unique case (c)
            CMD_WRITE_MEM:  decode_cmd = CC_WRMEM;
            CMD_READ_MEM:   decode_cmd = CC_RDMEM;
            CMD_READ_STAT:  decode_cmd = CC_STAT;
            CMD_SET_PROT:   decode_cmd = CC_PROT;
            CMD_SET_ADDR:   decode_cmd = CC_ADDR;
            CMD_READ_PORT:  decode_cmd = CC_RDPORT;
            CMD_WRITE_PORT: decode_cmd = CC_WRPORT;
            CMD_MASTER_RST: decode_cmd = CC_MRST;
            CMD_SCRIPT:     decode_cmd = CC_SCRIPT;
            CMD_BLOCK:      decode_cmd = CC_BLOCK;
            CMD_READ_BLK:   decode_cmd = CC_RDBLK;
            CMD_WRITE_BLK:  decode_cmd = CC_WRBLK;
            CMD_SEARCH:     decode_cmd = CC_SEARCH;
            CMD_FULL_SEQ:   decode_cmd = CC_FULL;
            CMD_CRC16:      decode_cmd = CC_CRC;
            default:        decode_cmd = CC_NONE;
        endcase
    endfunction

    icfe_state_t st_q;
    icfe_state_t st_d;
    icfe_cmd_t   cls_q;
    logic [7:0]  len_q;
    logic [7:0]  param_q;
    logic [5:0]  cnt_q;
    logic        bad_q;
    logic [7:0]  res_q;
    logic        rsp_len_q;
    logic        rsp_ready_q;
    logic [1:0]  rsp_idx_q;
    logic        rd_mode_q;
    logic [7:0]  page_buf_q [PAGE_BYTES];
    logic [2:0]  mem_page_q;
    logic [4:0]  mem_addr_q;
    logic [4:0]  mem_aout_q;
    logic [7:0]  mem_data_q;
    logic        mem_we_q;
    logic [3:0]  cls_out_q;
    logic        start_q;
    logic        mrst_q;

    // Named decode terms
    wire       take      = fb_valid && fb_ready;
    wire       is_addr   = take && fb_addr;
    wire       addr_read = fb_data[DIR_BIT];
    wire       is_stop   = take && fb_stop;
    wire       is_data   = take && !fb_addr && !fb_stop;
    wire [2:0] page_num  = param_q[PAGE_MSB:PAGE_LSB];
    wire       page_ok   = (param_q[7:3] == 5'h00)
                           && (page_num <= PAGE_LAST);
    wire       page_wp   = page_num[0];
    wire       len_ok    = (len_q == WR_MEM_LEN);
    wire       cnt_full  = (cnt_q == 6'(PAGE_BYTES));
    wire       wr_done   = (mem_addr_q == 5'(PAGE_BYTES-1));

    // Decoder stalls during check and programming
    assign fb_ready = (st_q != ST_CHECK) && (st_q != ST_PROG);

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: begin
                if (is_data && !rd_mode_q) begin
                    st_d = ST_LEN;
                end
            end
            ST_LEN: begin
                if (is_stop || is_addr) begin
                    st_d = ST_POST;
                end else if (is_data) begin
                    st_d = (cls_q == CC_WRMEM) ? ST_PARAM : ST_DATA;
                end
            end
            ST_PARAM: begin
                if (is_stop || is_addr) begin
                    st_d = ST_POST;
                end else if (is_data) begin
                    st_d = ST_DATA;
                end
            end
            ST_DATA: begin
                if (is_stop || is_addr) begin
                    st_d = (cls_q == CC_WRMEM) ? ST_CHECK : ST_POST;
                end
            end
            ST_CHECK: begin
                st_d = (bad_q || !len_ok || !page_ok || !cnt_full
                        || page_wp) ? ST_POST : ST_PROG;
            end
            ST_PROG: begin
                if (wr_done) begin
                    st_d = ST_POST;
                end
            end
            ST_POST: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Command capture and page buffer
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cls_q   <= CC_NONE;
            len_q   <= 8'h00;
            param_q <= 8'h00;
            cnt_q   <= 6'h00;
            bad_q   <= 1'b0;
        end else if (st_q == ST_IDLE && is_data && !rd_mode_q) begin
            cls_q <= decode_cmd(fb_data);
            cnt_q <= 6'h00;
            bad_q <= 1'b0;
        end else if (st_q == ST_LEN && is_data) begin
            len_q <= fb_data;
        end else if (st_q == ST_PARAM && is_data) begin
            param_q <= fb_data;
        end else if (st_q == ST_DATA && is_data) begin
            if (cnt_full) begin
                bad_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 6'h01;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (st_q == ST_DATA && is_data && !cnt_full) begin
            page_buf_q[cnt_q[4:0]] <= fb_data;
        end
    end

    // Programming port, one byte a cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mem_page_q <= 3'h0;
            mem_addr_q <= 5'h00;
            mem_aout_q <= 5'h00;
            mem_data_q <= 8'h00;
            mem_we_q   <= 1'b0;
        end else if (st_q == ST_PROG) begin
            mem_page_q <= page_num;
            mem_data_q <= page_buf_q[mem_addr_q];
            mem_we_q   <= 1'b1;
            mem_addr_q <= wr_done ? 5'h00 : mem_addr_q + 5'h01;
            mem_aout_q <= mem_addr_q;
        end else begin
            mem_we_q   <= 1'b0;
            mem_addr_q <= 5'h00;
        end
    end
    assign mem_page_out = mem_page_q;
    assign mem_addr_out = mem_aout_q;
    assign mem_data_out = mem_data_q;
    assign mem_we_out   = mem_we_q;

    // Result selection
    wire [7:0] wr_result = (bad_q || !len_ok || !page_ok || !cnt_full)
                           ? RES_INVALID
                           : page_wp ? RES_PROTECTED
                           : RES_SUCCESS;
    wire [7:0] post_result = (cls_q == CC_WRMEM) ? wr_result
                           : (cls_q == CC_NONE) ? RES_UNKNOWN
                           : RES_SUCCESS;

    // Class strobe and master reset pulse
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cls_out_q <= 4'h0;
            start_q   <= 1'b0;
            mrst_q    <= 1'b0;
        end else begin
            start_q <= (st_q == ST_POST) && (cls_q != CC_NONE)
                       && (cls_q != CC_WRMEM);
            mrst_q  <= (st_q == ST_POST) && (cls_q == CC_MRST);
            if (st_q == ST_POST) begin
                cls_out_q <= cls_q;
            end
        end
    end
    assign cmd_class_out    = cls_out_q;
    assign cmd_start_out    = start_q;
    assign master_reset_out = mrst_q;
    assign busy_out         = (st_q != ST_IDLE);

    // Response read: length then result
    wire tx_take = tx_valid_out && tx_ready_in;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            res_q       <= RES_UNKNOWN;
            rsp_ready_q <= 1'b0;
            rsp_idx_q   <= 2'h0;
            rd_mode_q   <= 1'b0;
            rsp_len_q   <= 1'b0;
        end else begin
            if (st_q == ST_POST) begin
                res_q       <= post_result;
                rsp_ready_q <= 1'b1;
            end
            if (is_addr) begin
                rd_mode_q <= addr_read;
                rsp_idx_q <= 2'h0;
                rsp_len_q <= addr_read && rsp_ready_q;
            end else if (is_stop) begin
                rd_mode_q <= 1'b0;
                rsp_len_q <= 1'b0;
            end else if (tx_take && rsp_idx_q != 2'h2) begin
                rsp_idx_q <= rsp_idx_q + 2'h1;
            end
        end
    end
    assign tx_valid_out = rd_mode_q;
    assign tx_byte_out  = (!rsp_len_q) ? RES_UNKNOWN
                        : (rsp_idx_q == 2'h0) ? WR_MEM_RSP_LEN
                        : (rsp_idx_q == 2'h1) ? res_q
                        : 8'hFF;
endmodule

/* File: icfe_pkg.sv */
// Constants and types for the command front end
package icfe_pkg;
    // Command codes
    localparam logic [7:0] CMD_WRITE_MEM  = 8'h96;
    localparam logic [7:0] CMD_READ_MEM   = 8'h44;
    localparam logic [7:0] CMD_SET_PROT   = 8'hC3;
    localparam logic [7:0] CMD_READ_STAT  = 8'hAA;
    localparam logic [7:0] CMD_SET_ADDR   = 8'h75;
    localparam logic [7:0] CMD_READ_PORT  = 8'h52;
    localparam logic [7:0] CMD_WRITE_PORT = 8'h99;
    localparam logic [7:0] CMD_MASTER_RST = 8'h62;
    localparam logic [7:0] CMD_SCRIPT     = 8'h88;
    localparam logic [7:0] CMD_BLOCK      = 8'hAB;
    localparam logic [7:0] CMD_READ_BLK   = 8'h50;
    localparam logic [7:0] CMD_WRITE_BLK  = 8'h68;
    localparam logic [7:0] CMD_SEARCH     = 8'h11;
    localparam logic [7:0] CMD_FULL_SEQ   = 8'h57;
    localparam logic [7:0] CMD_CRC16      = 8'hCC;
    // Result bytes
    localparam logic [7:0] RES_SUCCESS    = 8'hAA;
    localparam logic [7:0] RES_PROTECTED  = 8'h55;
    localparam logic [7:0] RES_INVALID    = 8'h77;
    localparam logic [7:0] RES_UNKNOWN    = 8'h22;
    // Page write layout
    localparam int         PAGE_BYTES     = 32;
    localparam int         PAGE_COUNT     = 6;
    localparam logic [7:0] WR_MEM_LEN     = 8'h21;
    localparam logic [7:0] WR_MEM_RSP_LEN = 8'h01;
    localparam int         PAGE_LSB       = 0;
    localparam int         PAGE_MSB       = 2;
    localparam logic [2:0] PAGE_LAST      = 3'h5;
    // Address byte direction bit
    localparam int         DIR_BIT        = 0;
    // Buffer depth
    localparam int         FIFO_DEPTH     = 8;
    // Command decode classes
    typedef enum logic [3:0] {
        CC_NONE   = 4'h0,
        CC_WRMEM  = 4'h1,
        CC_RDMEM  = 4'h2,
        CC_PROT   = 4'h3,
        CC_STAT   = 4'h4,
        CC_ADDR   = 4'h5,
        CC_RDPORT = 4'h6,
        CC_WRPORT = 4'h7,
        CC_MRST   = 4'h8,
        CC_SCRIPT = 4'h9,
        CC_BLOCK  = 4'hA,
        CC_RDBLK  = 4'hB,
        CC_WRBLK  = 4'hC,
        CC_SEARCH = 4'hD,
        CC_FULL   = 4'hE,
        CC_CRC    = 4'hF
    } icfe_cmd_t;
    // Front end states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE   = 7'b0000001,
        ST_LEN    = 7'b0000010,
        ST_PARAM  = 7'b0000100,
        ST_DATA   = 7'b0001000,
        ST_CHECK  = 7'b0010000,
        ST_PROG   = 7'b0100000,
        ST_POST   = 7'b1000000
    } icfe_state_t;
endpackage

/* File: icfe_fifo.sv */
// Small valid/ready FIFO
`timescale 1ns/1ps
module icfe_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Fill side
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    // Drain side
    output logic      [WIDTH-1:0] rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    wire              push;
    wire              pop;
    assign wr_ready_out = (cnt_q != (AW+1)'(DEPTH));
    assign rd_valid_out = (cnt_q != '0);
    assign rd_data_out  = mem_q[rp_q];
    assign push = wr_valid_in && wr_ready_out;
    assign pop  = rd_valid_out && rd_ready_in;
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wp_q] <= wr_data_in;
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* File: icfe_top_monitor.sv */
// Port checker for the command front end
`timescale 1ns/1ps
module icfe_top_monitor (
    // Clock and reset
    input wire logic       clk_in,
    input wire logic       rst_in,
    // Observed ports
    input wire logic       rx_ready_out,
    input wire logic [7:0] tx_byte_out,
    input wire logic       tx_valid_out,
    input wire logic       tx_ready_in,
    input wire logic [2:0] mem_page_out,
    input wire logic [4:0] mem_addr_out,
    input wire logic       mem_we_out,
    input wire logic       master_reset_out,
    input wire logic       busy_out
);
    default clocking @(posedge clk_in);
    endclocking
    // Reset seen at the previous edge
    logic rst_d_q;
    always_ff @(posedge clk_in) begin
        rst_d_q <= rst_in;
    end
    default disable iff (rst_in || rst_d_q);
    // Length of the current write burst
    logic [5:0] run_q;
    always_ff @(posedge clk_in) begin
        if (rst_in || !mem_we_out) begin
            run_q <= 6'h00;
        end else begin
            run_q <= run_q + 6'h01;
        end
    end
    a_we_first_addr: assert property ($rose(mem_we_out) |->
        mem_addr_out == 5'h00) else $error("burst not at byte 0");
    a_we_addr_step: assert property (mem_we_out && $past(mem_we_out)
        |-> mem_addr_out == $past(mem_addr_out) + 5'h01)
        else $error("burst address skipped");
    a_burst_len: assert property (!mem_we_out && $past(mem_we_out)
        |-> run_q == 6'h20) else $error("burst not 32 bytes");
    a_page_even: assert property (mem_we_out |->
        !mem_page_out[0]) else $error("odd page written");
    a_page_range: assert property (mem_we_out |->
        mem_page_out <= 3'h4) else $error("page out of range");
    a_we_busy: assert property (mem_we_out |-> busy_out)
        else $error("write while idle");
    a_tx_first_len: assert property ($rose(tx_valid_out) |->
        tx_byte_out == 8'h01) else $error("first byte not length");
    a_tx_hold: assert property (tx_valid_out && !tx_ready_in
        ##1 tx_valid_out |-> $stable(tx_byte_out))
        else $error("response byte changed");
    a_mrst_pulse: assert property (master_reset_out |=>
        !master_reset_out) else $error("reset pulse too long");
    c_burst: cover property (!mem_we_out && run_q == 6'h20);
    c_full: cover property (!rx_ready_out);
    c_mrst: cover property (master_reset_out);
endmodule
bind icfe_top icfe_top_monitor u_mon (
    .clk_in          (clk_in),
    .rst_in          (rst_in),
    .rx_ready_out    (rx_ready_out),
    .tx_byte_out     (tx_byte_out),
    .tx_valid_out    (tx_valid_out),
    .tx_ready_in     (tx_ready_in),
    .mem_page_out    (mem_page_out),
    .mem_addr_out    (mem_addr_out),
    .mem_we_out      (mem_we_out),
    .master_reset_out(master_reset_out),
    .busy_out        (busy_out)
);

/* File: icfe_host.sv */
// Host model: command writes and response reads
`timescale 1ns/1ps
module icfe_host (
    // Clock
    input  wire logic       clk_in,
    // Byte stream into the block
    output logic      [7:0] byte_out,
    output logic            valid_out,
    output logic            addr_out,
    output logic            stop_out,
    input  wire logic       ready_in,
    // Response stream
    input  wire logic [7:0] rsp_in,
    input  wire logic       rsp_valid_in,
    output logic            take_out
);
    localparam logic [6:0] SLV_ADDR = 7'h3C; // Arbitrary bus address
    initial begin
        byte_out = 8'h00;
        valid_out = 1'b0;
        addr_out = 1'b0;
        stop_out = 1'b0;
        take_out = 1'b0;
    end
    task automatic put(input logic a, s, input logic [7:0] b);
        @(posedge clk_in);
        byte_out <= b;
        valid_out <= 1'b1;
        addr_out <= a;
        stop_out <= s;
        do begin
            @(posedge clk_in);
        end while (!ready_in);
        valid_out <= 1'b0;
        addr_out <= 1'b0;
        stop_out <= 1'b0;
        byte_out <= ~b;
    endtask
    task automatic get(output logic [7:0] b);
        @(posedge clk_in);
        take_out <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (!rsp_valid_in);
        b = rsp_in;
        take_out <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] c, l, p, input int nd,
                       input logic [7:0] base);
        put(1'b1, 1'b0, {SLV_ADDR, 1'b0});
        put(1'b0, 1'b0, c);
        put(1'b0, 1'b0, l);
        put(1'b0, 1'b0, p);
        for (int i = 0; i < nd; i++) begin
            put(1'b0, 1'b0, base + 8'(i));
        end
        put(1'b0, 1'b1, 8'h00);
    endtask
    task automatic rsp(output logic [7:0] len, res);
        put(1'b1, 1'b0, {SLV_ADDR, 1'b1});
        get(len);
        get(res);
        put(1'b0, 1'b1, 8'h00);
    endtask
endmodule

/* File: tb.sv */
// Testbench for the command front end
`timescale 1ns/1ps
module tb;
    import icfe_pkg::*;
    typedef struct {
        logic [7:0] code, len, prm;
        int         nd;
        logic [7:0] res;
        int         nwr;
    } icfe_row_t;
    logic       clk_in;
    logic       rst_in = 1'b1;
    logic [7:0] rx_byte, tx_byte, mem_data, exp_base;
    logic       rx_valid, rx_ready, rx_addr, rx_stop, tx_valid, tx_ready;
    logic [2:0] mem_page, exp_pg;
    logic [4:0] mem_addr;
    logic       mem_we, cmd_start, mreset, busy;
    logic [3:0] cls;
    int         n_fail, comparisons, wr_n, st_n, mr_n, rf_n;
    // Page write cases and one unknown code
    icfe_row_t rows [10] = '{
        '{8'h96, 8'h21, 8'h00, 32, 8'hAA, 32},
        '{8'h96, 8'h21, 8'h04, 32, 8'hAA, 32},
        '{8'h96, 8'h21, 8'h01, 32, 8'h55, 0},
        '{8'h96, 8'h21, 8'h05, 32, 8'h55, 0},
        '{8'h96, 8'h21, 8'h06, 32, 8'h77, 0},
        '{8'h96, 8'h21, 8'h0C, 32, 8'h77, 0},
        '{8'h96, 8'h20, 8'h00, 32, 8'h77, 0},
        '{8'h96, 8'h21, 8'h02, 31, 8'h77, 0},
        '{8'h96, 8'h21, 8'h02, 33, 8'h77, 0},
        '{8'h3C, 8'h01, 8'h00, 0, 8'h22, 0}};
    // Other codes in class order 2 to 15
    logic [7:0] codes [14] = '{8'h44, 8'hC3, 8'hAA, 8'h75, 8'h52, 8'h99,
        8'h62, 8'h88, 8'hAB, 8'h50, 8'h68, 8'h11, 8'h57, 8'hCC};
    icfe_top dut (.clk_in(clk_in), .rst_in(rst_in), .rx_byte_in(rx_byte),
        .rx_valid_in(rx_valid), .rx_ready_out(rx_ready),
        .rx_addr_in(rx_addr), .rx_stop_in(rx_stop), .tx_byte_out(tx_byte),
        .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
        .mem_page_out(mem_page), .mem_addr_out(mem_addr),
        .mem_data_out(mem_data), .mem_we_out(mem_we),
        .cmd_class_out(cls), .cmd_start_out(cmd_start),
        .master_reset_out(mreset), .busy_out(busy));
    icfe_host host (.clk_in(clk_in), .byte_out(rx_byte),
        .valid_out(rx_valid), .addr_out(rx_addr), .stop_out(rx_stop),
        .ready_in(rx_ready), .rsp_in(tx_byte), .rsp_valid_in(tx_valid),
        .take_out(tx_ready));
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (!ok) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Wait until idle for four cycles in a row
    task automatic settle();
        int n, q;
        n = 0;
        q = 0;
        do begin
            @(posedge clk_in);
            n++;
            q = (busy === 1'b0) ? q + 1 : 0;
        end while (q < 4 && n < 500);
        if (q < 4) begin
            n_fail++;
            $display("wrong value at %0t: still busy", $time);
        end
    endtask
    task automatic answer(input logic [7:0] xr);
        logic [7:0] rl, rr;
        host.rsp(rl, rr);
        chk(rl === 8'h01, "length byte");
        chk(rr === xr, "result byte");
    endtask
    always @(posedge clk_in) begin
        if (mem_we === 1'b1) begin
            chk(mem_addr === wr_n[4:0] && mem_page === exp_pg, "addr");
            chk(mem_data === exp_base + wr_n[7:0], "data");
            wr_n++;
        end
        if (cmd_start === 1'b1) st_n++;
        if (mreset === 1'b1) mr_n++;
        if (rx_ready === 1'b0) rf_n++;
    end
    initial begin
        #(20000 * 20);
        n_fail++;
        give_verdict();
    end
    initial begin
        int n;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        chk(tx_byte === RES_UNKNOWN && busy === 1'b0, "reset");
        chk(tx_valid === 1'b0 && mem_we === 1'b0 && rx_ready === 1'b1, "rst");
        for (int i = 0; i < 10; i++) begin
            exp_pg = rows[i].prm[2:0];
            exp_base = 8'h30 + 8'(16 * i);
            wr_n = 0;
            st_n = 0;
            host.cmd(rows[i].code, rows[i].len, rows[i].prm, rows[i].nd,
                     exp_base);
            settle();
            answer(rows[i].res);
            chk(wr_n === rows[i].nwr && st_n === 0, "written");
            if (rows[i].code === 8'h96) chk(cls === CC_WRMEM, "class");
            else chk(cls === CC_NONE, "class");
        end
        for (int i = 0; i < 14; i++) begin
            st_n = 0;
            mr_n = 0;
            host.cmd(codes[i], 8'h01, 8'h00, 0, 8'h00);
            settle();
            answer(RES_SUCCESS);
            chk(cls === 4'(i + 2), "decode");
            chk(st_n === 1, "start");
            chk(mr_n === (codes[i] === 8'h62 ? 1 : 0), "mreset");
        end
        wr_n = 0;
        st_n = 0;
        rf_n = 0;
        exp_pg = 3'h2;
        exp_base = 8'hC0;
        host.cmd(8'h96, 8'h21, 8'h02, 32, 8'hC0);
        host.cmd(8'h88, 8'h09, 8'h00, 8, 8'h10);
        settle();
        answer(RES_SUCCESS);
        chk(wr_n === 32 && st_n === 1 && rf_n > 0, "queued");
        chk(cls === CC_SCRIPT, "queued class");
        wr_n = 0;
        exp_pg = 3'h4;
        exp_base = 8'h50;
        host.cmd(8'h96, 8'h21, 8'h04, 32, 8'h50);
        n = 0;
        while (mem_we !== 1'b1 && n < 200) begin
            @(posedge clk_in);
            n++;
        end
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        chk(busy === 1'b0 && mem_we === 1'b0 && tx_byte === RES_UNKNOWN, "mid");
        chk(wr_n > 0 && wr_n < 32, "burst cut");
        give_verdict();
    end
endmodule
